// [rtl/vcpu_prio_pkg.sv]
// Constants for the virtual CPU interface priority and control registers
package vcpu_prio_pkg;

	// ==========================================================
	// System register encodings {op0, op1, crn, crm, op2}
	localparam int ENC_W = 17;
	localparam logic [ENC_W-1:0] ENC_VIRT_G1_ACTIVE = {2'h3, 3'h0, 5'h0C, 4'h9, 3'h0};
	localparam logic [ENC_W-1:0] ENC_VIRT_G0_SPLIT  = {2'h3, 3'h0, 5'h0C, 4'h8, 3'h3};
	localparam logic [ENC_W-1:0] ENC_VIRT_G1_SPLIT  = {2'h3, 3'h0, 5'h0C, 4'hC, 3'h3};
	localparam logic [ENC_W-1:0] ENC_VIRT_CONTROL   = {2'h3, 3'h0, 5'h0C, 4'hC, 3'h4};
	localparam logic [ENC_W-1:0] ENC_HYP_G0_ACTIVE  = {2'h3, 3'h0, 5'h0C, 4'h8, 3'h4};
	localparam logic [ENC_W-1:0] ENC_HYP_G1_ACTIVE  = {2'h3, 3'h0, 5'h13, 4'h9, 3'h0};

	// ==========================================================
	// Active-priority bitmaps
	localparam int          AP_W        = 32;
	localparam int          PRIO_BITS   = 5;
	localparam int          PRIO_LSB    = 3;
	localparam logic [31:0] AP_RESET    = 32'h0000_0000;

	// ==========================================================
	// Split-point fields
	localparam int         SPLIT_W        = 3;
	localparam logic [2:0] SPLIT_G0_MIN   = 3'h2;
	localparam logic [2:0] SPLIT_G1_S_MIN = 3'h2;
	localparam logic [2:0] SPLIT_G1_NS_MIN = 3'h3;
	localparam logic [2:0] SPLIT_MAX      = 3'h7;
	localparam logic [2:0] SPLIT_STEP     = 3'h1;

	// ==========================================================
	// Control register fields
	localparam int         CTL_CBPR_BIT   = 0;
	localparam int         CTL_EOI_BIT    = 1;
	localparam int         CTL_PRI_LSB    = 8;
	localparam int         CTL_ID_LSB     = 11;
	localparam int         CTL_SYS_ERR_BIT = 14;
	localparam int         CTL_AFF3_BIT   = 15;
	localparam logic [2:0] CTL_PRI_CODE   = 3'h4;
	localparam logic [2:0] CTL_ID_CODE    = 3'h0;
	localparam logic       CTL_SYS_ERR_VAL = 1'h0;
	localparam logic       CTL_AFF3_VAL   = 1'h1;
	localparam logic       CTL_EOI_RESET  = 1'h0;
	localparam logic       CTL_CBPR_RESET = 1'h0;

endpackage : vcpu_prio_pkg

// [rtl/active_prio_bitmap.sv]
// One active-priority bitmap with acknowledge set and priority-drop clear
`timescale 1ns/10ps
module active_prio_bitmap (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	input  wire logic        set_en,
	input  wire logic [4:0]  set_idx,
	input  wire logic        drop_en,
	output logic      [31:0] value
);

	logic [31:0] next_value;
	logic [31:0] lowest;

	// ==========================================================
	// Next state
	always_comb begin
		// Highest active priority is the lowest set bit
		lowest     = value & (~value + 32'h0000_0001);
		next_value = value;
		if (wr_en) begin
			next_value = wr_data;
		end else if (drop_en) begin
			next_value = value & ~lowest;
		end
		// Set wins over a drop in the same cycle
		if (set_en) begin
			next_value[set_idx] = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value <= vcpu_prio_pkg::AP_RESET;
		end else begin
			value <= next_value;
		end
	end

	// ==========================================================
	// Assertions
	property p_set_marks;
		@(posedge clk) disable iff (!rst_n)
		set_en |=> value[$past(set_idx)];
	endproperty
	a_set_marks: assert property (p_set_marks) else $error("ack did not mark level");

	property p_drop_lowest;
		@(posedge clk) disable iff (!rst_n)
		(drop_en && !set_en && !wr_en) |=> value == ($past(value) & ~$past(lowest));
	endproperty
	a_drop_lowest: assert property (p_drop_lowest) else $error("drop cleared wrong bit");

	property p_reset_empty;
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> value == 32'h0000_0000;
	endproperty
	a_reset_empty: assert property (p_reset_empty) else $error("bitmap not empty at reset");

endmodule : active_prio_bitmap

// [rtl/virtual_cpu_iface_priority_regs.sv]
// Virtual CPU interface active priorities, split points and control register
//
// Summary of operation
// - Active-priority bit n marks an active interrupt at priority n times eight.
// - Every active-priority bitmap resets to all zeros.
// - Five priority bits are used, giving thirty-two levels.
// - Group 0 split point in bits 2:0, never below 2.
// - Group 1 split point minimum is 2 when secure, 3 when non-secure.
// - Control bit 15 reads one: affinity level 3 supported.
// - Control bit 14 reads zero: no local system error interrupts.
// - Control bits 13:11 read zero: sixteen identifier bits.
// - Control bits 10:8 read four: five priority bits.
// - Mode bit clear: end-of-interrupt drops priority and deactivates.
// - Mode bit set: end-of-interrupt only drops; deactivation register deactivates.
// - Common bit clear: each group uses its own split point.
// - Common bit set: group 0 split governs both; group 1 reads plus one, saturated.
// - Common bit set: writes to group 1 split point are ignored.
`timescale 1ns/10ps
module virtual_cpu_iface_priority_regs (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sys_wr,
	input  wire logic        sys_rd,
	input  wire logic [1:0]  sys_op0,
	input  wire logic [2:0]  sys_op1,
	input  wire logic [4:0]  sys_crn,
	input  wire logic [3:0]  sys_crm,
	input  wire logic [2:0]  sys_op2,
	input  wire logic [31:0] sys_wdata,
	output logic      [31:0] sys_rdata,
	output logic             sys_rd_valid,
	output logic             sys_undef,
	input  wire logic        secure_state,
	input  wire logic        ack_valid,
	input  wire logic        ack_hyp,
	input  wire logic        ack_group,
	input  wire logic [7:0]  ack_priority,
	input  wire logic        eoi_wr,
	input  wire logic        eoi_hyp,
	input  wire logic        eoi_group,
	input  wire logic        dir_wr,
	output logic             priority_drop,
	output logic             deactivate,
	output logic      [2:0]  g0_split_point,
	output logic      [2:0]  g1_split_point,
	output logic             split_eoi_mode,
	output logic             common_split_point
);

	// ==========================================================
	// Decode
	logic [16:0] enc;
	logic        hit_vap1;
	logic        hit_bpr0;
	logic        hit_bpr1;
	logic        hit_ctlr;
	logic        hit_hap0;
	logic        hit_hap1;
	logic        hit_any;

	assign enc      = {sys_op0, sys_op1, sys_crn, sys_crm, sys_op2};
	assign hit_vap1 = (enc == vcpu_prio_pkg::ENC_VIRT_G1_ACTIVE);
	assign hit_bpr0 = (enc == vcpu_prio_pkg::ENC_VIRT_G0_SPLIT);
	assign hit_bpr1 = (enc == vcpu_prio_pkg::ENC_VIRT_G1_SPLIT);
	assign hit_ctlr = (enc == vcpu_prio_pkg::ENC_VIRT_CONTROL);
	assign hit_hap0 = (enc == vcpu_prio_pkg::ENC_HYP_G0_ACTIVE);
	assign hit_hap1 = (enc == vcpu_prio_pkg::ENC_HYP_G1_ACTIVE);
	assign hit_any  = hit_vap1 | hit_bpr0 | hit_bpr1 | hit_ctlr | hit_hap0 | hit_hap1;

	// ==========================================================
	// Active-priority bitmaps
	logic [31:0] vap1_value;
	logic [31:0] hap0_value;
	logic [31:0] hap1_value;
	logic [4:0]  ack_idx;

	// Low three bits are subpriority below the implemented levels
	assign ack_idx = ack_priority[vcpu_prio_pkg::PRIO_LSB +: vcpu_prio_pkg::PRIO_BITS];

	active_prio_bitmap u_virt_g1 (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (sys_wr & hit_vap1),
		.wr_data (sys_wdata),
		.set_en  (ack_valid & ~ack_hyp & ack_group),
		.set_idx (ack_idx),
		.drop_en (eoi_wr & ~eoi_hyp & eoi_group),
		.value   (vap1_value)
	);

	active_prio_bitmap u_hyp_g0 (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (sys_wr & hit_hap0),
		.wr_data (sys_wdata),
		.set_en  (ack_valid & ack_hyp & ~ack_group),
		.set_idx (ack_idx),
		.drop_en (eoi_wr & eoi_hyp & ~eoi_group),
		.value   (hap0_value)
	);

	active_prio_bitmap u_hyp_g1 (
		.clk     (clk),
		.rst_n   (rst_n),
		.wr_en   (sys_wr & hit_hap1),
		.wr_data (sys_wdata),
		.set_en  (ack_valid & ack_hyp & ack_group),
		.set_idx (ack_idx),
		.drop_en (eoi_wr & eoi_hyp & eoi_group),
		.value   (hap1_value)
	);

	// ==========================================================
	// Split points and control bits
	logic [2:0] bpr0;
	logic [2:0] bpr1_s;
	logic [2:0] bpr1_ns;
	logic [2:0] next_bpr0;
	logic [2:0] next_bpr1_s;
	logic [2:0] next_bpr1_ns;
	logic       next_split_eoi_mode;
	logic       next_common_split_point;
	logic [2:0] bpr1_cur;
	logic [2:0] bpr0_plus;
	logic [2:0] bpr1_view;

	function automatic logic [2:0] clamp_split(input logic [2:0] v, input logic [2:0] lo);
		clamp_split = (v < lo) ? lo : v;
	endfunction : clamp_split

	assign bpr1_cur  = secure_state ? bpr1_s : bpr1_ns;
	assign bpr0_plus = (bpr0 == vcpu_prio_pkg::SPLIT_MAX) ? vcpu_prio_pkg::SPLIT_MAX
	                   : bpr0 + vcpu_prio_pkg::SPLIT_STEP;
	assign bpr1_view = common_split_point ? bpr0_plus : bpr1_cur;

	always_comb begin
		next_bpr0               = bpr0;
		next_bpr1_s             = bpr1_s;
		next_bpr1_ns            = bpr1_ns;
		next_split_eoi_mode     = split_eoi_mode;
		next_common_split_point = common_split_point;
		if (sys_wr && hit_bpr0) begin
			next_bpr0 = clamp_split(sys_wdata[2:0], vcpu_prio_pkg::SPLIT_G0_MIN);
		end
		// Writes are dropped while group 0 governs both groups
		if (sys_wr && hit_bpr1 && !common_split_point) begin
			if (secure_state) begin
				next_bpr1_s = clamp_split(sys_wdata[2:0], vcpu_prio_pkg::SPLIT_G1_S_MIN);
			end else begin
				next_bpr1_ns = clamp_split(sys_wdata[2:0], vcpu_prio_pkg::SPLIT_G1_NS_MIN);
			end
		end
		// Only the two mode bits are writable; the rest is fixed
		if (sys_wr && hit_ctlr) begin
			next_split_eoi_mode     = sys_wdata[vcpu_prio_pkg::CTL_EOI_BIT];
			next_common_split_point = sys_wdata[vcpu_prio_pkg::CTL_CBPR_BIT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bpr0               <= vcpu_prio_pkg::SPLIT_G0_MIN;
			bpr1_s             <= vcpu_prio_pkg::SPLIT_G1_S_MIN;
			bpr1_ns            <= vcpu_prio_pkg::SPLIT_G1_NS_MIN;
			split_eoi_mode     <= vcpu_prio_pkg::CTL_EOI_RESET;
			common_split_point <= vcpu_prio_pkg::CTL_CBPR_RESET;
		end else begin
			bpr0               <= next_bpr0;
			bpr1_s             <= next_bpr1_s;
			bpr1_ns            <= next_bpr1_ns;
			split_eoi_mode     <= next_split_eoi_mode;
			common_split_point <= next_common_split_point;
		end
	end

	// ==========================================================
	// Read path and interrupt completion pulses
	logic [31:0] ctlr_view;
	logic [31:0] next_sys_rdata;
	logic        next_sys_rd_valid;
	logic        next_sys_undef;
	logic        next_priority_drop;
	logic        next_deactivate;
	logic [2:0]  next_g0_split_point;
	logic [2:0]  next_g1_split_point;

	always_comb begin
		ctlr_view = 32'h0000_0000;
		ctlr_view[vcpu_prio_pkg::CTL_AFF3_BIT]    = vcpu_prio_pkg::CTL_AFF3_VAL;
		ctlr_view[vcpu_prio_pkg::CTL_SYS_ERR_BIT] = vcpu_prio_pkg::CTL_SYS_ERR_VAL;
		ctlr_view[vcpu_prio_pkg::CTL_ID_LSB +: 3]  = vcpu_prio_pkg::CTL_ID_CODE;
		ctlr_view[vcpu_prio_pkg::CTL_PRI_LSB +: 3] = vcpu_prio_pkg::CTL_PRI_CODE;
		ctlr_view[vcpu_prio_pkg::CTL_EOI_BIT]  = split_eoi_mode;
		ctlr_view[vcpu_prio_pkg::CTL_CBPR_BIT] = common_split_point;
	end

	always_comb begin
		next_sys_rdata = sys_rdata;
		if (sys_rd) begin
			next_sys_rdata = 32'h0000_0000;
			if (hit_vap1) next_sys_rdata = vap1_value;
			if (hit_hap0) next_sys_rdata = hap0_value;
			if (hit_hap1) next_sys_rdata = hap1_value;
			if (hit_bpr0) next_sys_rdata = {29'h0000_0000, bpr0};
			if (hit_bpr1) next_sys_rdata = {29'h0000_0000, bpr1_view};
			if (hit_ctlr) next_sys_rdata = ctlr_view;
		end
		next_sys_rd_valid  = sys_rd;
		next_sys_undef     = (sys_rd | sys_wr) & ~hit_any;
		next_priority_drop = eoi_wr;
		// Deactivation requests in combined mode are ignored
		next_deactivate     = (eoi_wr & ~split_eoi_mode)
		                    | (dir_wr & split_eoi_mode);
		next_g0_split_point = bpr0;
		next_g1_split_point = common_split_point ? bpr0 : bpr1_cur;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_rdata      <= 32'h0000_0000;
			sys_rd_valid   <= 1'b0;
			sys_undef      <= 1'b0;
			priority_drop  <= 1'b0;
			deactivate     <= 1'b0;
			g0_split_point <= vcpu_prio_pkg::SPLIT_G0_MIN;
			g1_split_point <= vcpu_prio_pkg::SPLIT_G1_NS_MIN;
		end else begin
			sys_rdata      <= next_sys_rdata;
			sys_rd_valid   <= next_sys_rd_valid;
			sys_undef      <= next_sys_undef;
			priority_drop  <= next_priority_drop;
			deactivate     <= next_deactivate;
			g0_split_point <= next_g0_split_point;
			g1_split_point <= next_g1_split_point;
		end
	end

	// ==========================================================
	// Assertions
	logic       rd_ctlr_q;
	logic       rd_bpr0_q;
	logic       rd_bpr1_q;
	logic [2:0] bpr1_expect_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ctlr_q     <= 1'b0;
			rd_bpr0_q     <= 1'b0;
			rd_bpr1_q     <= 1'b0;
			bpr1_expect_q <= 3'h0;
		end else begin
			rd_ctlr_q     <= sys_rd & hit_ctlr;
			rd_bpr0_q     <= sys_rd & hit_bpr0;
			rd_bpr1_q     <= sys_rd & hit_bpr1 & common_split_point;
			bpr1_expect_q <= (bpr0 == 3'h7) ? 3'h7 : bpr0 + 3'h1;
		end
	end

	property p_ctlr_fixed;
		@(posedge clk) disable iff (!rst_n)
		rd_ctlr_q |-> (sys_rd_valid && sys_rdata[31:8] == 24'h0000_84 && sys_rdata[7:2] == 6'h00);
	endproperty
	a_ctlr_fixed: assert property (p_ctlr_fixed) else $error("control fixed fields wrong");

	property p_g0_min;
		@(posedge clk) disable iff (!rst_n)
		rd_bpr0_q |-> (sys_rdata[31:3] == 29'h0000_0000 && sys_rdata[2:0] >= 3'h2);
	endproperty
	a_g0_min: assert property (p_g0_min) else $error("group 0 split below minimum");

	property p_g1_min;
		@(posedge clk) disable iff (!rst_n)
		(bpr1_s >= 3'h2) && (bpr1_ns >= 3'h3);
	endproperty
	a_g1_min: assert property (p_g1_min) else $error("group 1 split below minimum");

	property p_g1_common_read;
		@(posedge clk) disable iff (!rst_n)
		rd_bpr1_q |-> sys_rdata == {29'h0000_0000, bpr1_expect_q};
	endproperty
	a_g1_common_read: assert property (p_g1_common_read) else $error("common read not saturated");

	property p_g1_write_ignored;
		@(posedge clk) disable iff (!rst_n)
		(sys_wr && hit_bpr1 && common_split_point) |=> ($stable(bpr1_s) && $stable(bpr1_ns));
	endproperty
	a_g1_write_ignored: assert property (p_g1_write_ignored) else $error("ignored write took effect");

	property p_combined_eoi;
		@(posedge clk) disable iff (!rst_n)
		(eoi_wr && !split_eoi_mode) |=> (deactivate && priority_drop);
	endproperty
	a_combined_eoi: assert property (p_combined_eoi) else $error("eoi did not deactivate");

	property p_split_eoi;
		@(posedge clk) disable iff (!rst_n)
		(eoi_wr && split_eoi_mode && !dir_wr) |=> (priority_drop && !deactivate);
	endproperty
	a_split_eoi: assert property (p_split_eoi) else $error("split eoi deactivated");

	property p_split_dir;
		@(posedge clk) disable iff (!rst_n)
		(dir_wr && split_eoi_mode) |=> deactivate;
	endproperty
	a_split_dir: assert property (p_split_dir) else $error("deactivation write lost");

	property p_separate_split;
		@(posedge clk) disable iff (!rst_n)
		(!common_split_point && !sys_wr) |=> (g1_split_point == $past(bpr1_cur)
		                                      && g0_split_point == $past(bpr0));
	endproperty
	a_separate_split: assert property (p_separate_split) else $error("group split mixed up");

	property p_ack_level;
		@(posedge clk) disable iff (!rst_n)
		(ack_valid && !ack_hyp && ack_group) |=> vap1_value[$past(ack_priority[7:3])];
	endproperty
	a_ack_level: assert property (p_ack_level) else $error("ack level not mapped");

	c_common_read: cover property (@(posedge clk) disable iff (!rst_n) rd_bpr1_q);
	c_split_dir: cover property (@(posedge clk) disable iff (!rst_n) dir_wr && split_eoi_mode);
	c_lowest_prio: cover property (@(posedge clk) disable iff (!rst_n) ack_valid && ack_idx == 5'h1F);
	c_drop_empty: cover property (@(posedge clk) disable iff (!rst_n) priority_drop && vap1_value == 32'h0);

endmodule : virtual_cpu_iface_priority_regs

// [bench/virtual_cpu_iface_priority_regs_tb.sv]
// Self-checking bench for the virtual CPU interface priority and control registers
`timescale 1ns/10ps
module virtual_cpu_iface_priority_regs_tb;
	// ==========================================================
	// Signals
	logic        clk;
	logic        rst_n;
	logic        sys_wr;
	logic        sys_rd;
	logic [16:0] enc;
	logic [31:0] sys_wdata;
	logic [31:0] sys_rdata;
	logic        sys_rd_valid;
	logic        sys_undef;
	logic        secure_state;
	logic        ack_valid;
	logic        ack_hyp;
	logic        ack_group;
	logic [7:0]  ack_priority;
	logic        eoi_wr;
	logic        eoi_hyp;
	logic        eoi_group;
	logic        dir_wr;
	logic        priority_drop;
	logic        deactivate;
	logic [2:0]  g0_split_point;
	logic [2:0]  g1_split_point;
	logic        split_eoi_mode;
	logic        common_split_point;
	int          seed;
	int          n_errors;
	int          tests_run;
	logic        last_undef;
	logic [31:0] rd;
	logic [31:0] exp_ap [3];
	logic [2:0]  exp_b0;
	logic [2:0]  exp_b1 [2];
	logic [16:0] ap_enc [3];

	virtual_cpu_iface_priority_regs dut (
		.clk(clk), .rst_n(rst_n), .sys_wr(sys_wr), .sys_rd(sys_rd),
		.sys_op0(enc[16:15]), .sys_op1(enc[14:12]), .sys_crn(enc[11:7]),
		.sys_crm(enc[6:3]), .sys_op2(enc[2:0]), .sys_wdata(sys_wdata),
		.sys_rdata(sys_rdata), .sys_rd_valid(sys_rd_valid), .sys_undef(sys_undef),
		.secure_state(secure_state), .ack_valid(ack_valid), .ack_hyp(ack_hyp),
		.ack_group(ack_group), .ack_priority(ack_priority), .eoi_wr(eoi_wr),
		.eoi_hyp(eoi_hyp), .eoi_group(eoi_group), .dir_wr(dir_wr),
		.priority_drop(priority_drop), .deactivate(deactivate),
		.g0_split_point(g0_split_point), .g1_split_point(g1_split_point),
		.split_eoi_mode(split_eoi_mode), .common_split_point(common_split_point)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Expectation helpers
	function automatic int tgt(input logic h, input logic g);
		return h ? (g ? 2 : 1) : (g ? 0 : -1);
	endfunction : tgt

	function automatic logic [2:0] clamp(input logic [2:0] v, input logic [2:0] lo);
		return (v < lo) ? lo : v;
	endfunction : clamp

	function automatic logic [31:0] ctl_exp(input logic m, input logic c);
		return {16'h0000, 1'b1, 1'b0, 3'h0, 3'h4, 6'h00, m, c};
	endfunction : ctl_exp

	// ==========================================================
	// Bus and strobe tasks, entered one step after a rising edge
	// An idle cycle ends each, so no strobe rises in the step where it fell
	task automatic tick;
		@(posedge clk);
		#1;
	endtask : tick

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic reg_rd(input logic [16:0] e, output logic [31:0] d);
		enc = e;
		sys_rd = 1'b1;
		tick();
		sys_rd = 1'b0;
		chk({31'h0, sys_rd_valid}, 32'h1, "read valid");
		last_undef = sys_undef;
		d = sys_rdata;
		tick();
	endtask : reg_rd

	task automatic rd_chk(input logic [16:0] e, input logic [31:0] exp, input string what);
		logic [31:0] d;
		reg_rd(e, d);
		chk(d, exp, what);
	endtask : rd_chk

	task automatic reg_wr(input logic [16:0] e, input logic [31:0] d);
		enc = e;
		sys_wdata = d;
		sys_wr = 1'b1;
		tick();
		sys_wr = 1'b0;
		tick();
	endtask : reg_wr

	task automatic do_ack(input logic h, input logic g, input logic [4:0] p);
		logic [31:0] r;
		r = $random(seed);
		ack_hyp = h;
		ack_group = g;
		ack_priority = {p, r[2:0]};
		ack_valid = 1'b1;
		tick();
		ack_valid = 1'b0;
		tick();
		if (tgt(h, g) >= 0)
			exp_ap[tgt(h, g)][p] = 1'b1;
	endtask : do_ack

	task automatic do_eoi(input logic h, input logic g, input logic m);
		eoi_hyp = h;
		eoi_group = g;
		eoi_wr = 1'b1;
		tick();
		eoi_wr = 1'b0;
		chk({31'h0, priority_drop}, 32'h1, "drop pulse");
		chk({31'h0, deactivate}, {31'h0, ~m}, "deactivate on eoi");
		if (tgt(h, g) >= 0)
			exp_ap[tgt(h, g)] = exp_ap[tgt(h, g)] & (exp_ap[tgt(h, g)] - 32'h1);
		tick();
	endtask : do_eoi

	task automatic do_dir(input logic m);
		dir_wr = 1'b1;
		tick();
		dir_wr = 1'b0;
		chk({31'h0, deactivate}, {31'h0, m}, "deactivate on dir");
		tick();
	endtask : do_dir

	task automatic chk_maps;
		for (int i = 0; i < 3; i++)
			rd_chk(ap_enc[i], exp_ap[i], "bitmap");
	endtask : chk_maps

	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict

	// ==========================================================
	// Watchdog, far beyond the roughly 320 cycles of the sequence
	initial begin
		#50000;
		n_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		give_verdict();
	end

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] r;
		seed = 37;
		n_errors = 0;
		tests_run = 0;
		{sys_wr, sys_rd, enc, sys_wdata, secure_state} = '0;
		{ack_valid, ack_hyp, ack_group, ack_priority} = '0;
		{eoi_wr, eoi_hyp, eoi_group, dir_wr} = '0;
		ap_enc = '{vcpu_prio_pkg::ENC_VIRT_G1_ACTIVE, vcpu_prio_pkg::ENC_HYP_G0_ACTIVE,
			vcpu_prio_pkg::ENC_HYP_G1_ACTIVE};
		exp_ap = '{32'h0, 32'h0, 32'h0};
		rst_n = 1'b0;
		repeat (3) @(posedge clk);
		#1;
		rst_n = 1'b1;

		chk_maps();
		rd_chk(vcpu_prio_pkg::ENC_VIRT_CONTROL, ctl_exp(1'b0, 1'b0), "ctl reset");
		rd_chk(vcpu_prio_pkg::ENC_VIRT_G0_SPLIT, 32'h2, "g0 split reset");
		rd_chk(vcpu_prio_pkg::ENC_VIRT_G1_SPLIT, 32'h3, "g1 split reset");
		chk({31'h0, last_undef}, 32'h0, "mapped flag");
		rd_chk(17'h00000, 32'h0, "unmapped read");
		chk({31'h0, last_undef}, 32'h1, "unmapped flag");
		$display("test reset done");

		// Lowest and highest levels, then random traffic
		do_ack(1'b0, 1'b1, 5'h00);
		do_ack(1'b0, 1'b1, 5'h1F);
		for (int i = 0; i < 40; i++) begin
			r = $random(seed);
			do_ack(r[5], r[6], r[4:0]);
		end
		chk_maps();
		for (int i = 0; i < 12; i++) begin
			r = $random(seed);
			do_eoi(r[0], r[1], 1'b0);
		end
		do_dir(1'b0);
		chk_maps();
		$display("test acknowledge and drop done");

		// Split end-of-interrupt mode; reserved control bits ignore ones
		reg_wr(vcpu_prio_pkg::ENC_VIRT_CONTROL, 32'hFFFF_FFFE);
		rd_chk(vcpu_prio_pkg::ENC_VIRT_CONTROL, ctl_exp(1'b1, 1'b0), "ctl mode");
		chk({31'h0, split_eoi_mode}, 32'h1, "mode out");
		do_eoi(1'b0, 1'b1, 1'b1);
		do_dir(1'b1);
		for (int i = 0; i < 3; i++) begin
			r = $random(seed);
			reg_wr(ap_enc[i], r);
			exp_ap[i] = r;
		end
		chk_maps();
		$display("test eoi mode done");

		// Split points: every value, both security copies, reserved bits set
		for (int v = 0; v < 8; v++) begin
			exp_b0 = clamp(3'(v), 3'h2);
			reg_wr(vcpu_prio_pkg::ENC_VIRT_G0_SPLIT, {29'h1FFF_FFFF, 3'(v)});
			rd_chk(vcpu_prio_pkg::ENC_VIRT_G0_SPLIT, {29'h0, exp_b0}, "g0 split");
			chk({29'h0, g0_split_point}, {29'h0, exp_b0}, "g0 split out");
			for (int s = 0; s < 2; s++) begin
				secure_state = s[0];
				exp_b1[s] = clamp(3'(v), s ? 3'h2 : 3'h3);
				reg_wr(vcpu_prio_pkg::ENC_VIRT_G1_SPLIT, {29'h1FFF_FFFF, 3'(v)});
				rd_chk(vcpu_prio_pkg::ENC_VIRT_G1_SPLIT, {29'h0, exp_b1[s]}, "g1 split");
				chk({29'h0, g1_split_point}, {29'h0, exp_b1[s]}, "g1 split out");
			end
		end
		$display("test split points done");

		// Common split point: group 1 reads plus one and ignores writes
		reg_wr(vcpu_prio_pkg::ENC_VIRT_CONTROL, 32'h0000_0001);
		chk({31'h0, common_split_point}, 32'h1, "common out");
		for (int v = 0; v < 8; v++) begin
			exp_b0 = clamp(3'(v), 3'h2);
			r = $random(seed);
			reg_wr(vcpu_prio_pkg::ENC_VIRT_G0_SPLIT, {29'h0, 3'(v)});
			reg_wr(vcpu_prio_pkg::ENC_VIRT_G1_SPLIT, r);
			rd_chk(vcpu_prio_pkg::ENC_VIRT_G1_SPLIT,
				{29'h0, (exp_b0 == 3'h7) ? 3'h7 : exp_b0 + 3'h1}, "g1 common");
			chk({29'h0, g1_split_point}, {29'h0, exp_b0}, "g1 common out");
		end
		reg_wr(vcpu_prio_pkg::ENC_VIRT_CONTROL, 32'h0000_0000);
		rd_chk(vcpu_prio_pkg::ENC_VIRT_G1_SPLIT, {29'h0, exp_b1[1]}, "g1 kept");
		secure_state = 1'b0;
		rd_chk(vcpu_prio_pkg::ENC_VIRT_G1_SPLIT, {29'h0, exp_b1[0]}, "g1 ns kept");
		$display("test common split done");

		// Reset in mid-run empties the bitmaps filled above
		rst_n = 1'b0;
		tick();
		rst_n = 1'b1;
		exp_ap = '{32'h0, 32'h0, 32'h0};
		chk_maps();
		rd_chk(vcpu_prio_pkg::ENC_VIRT_G0_SPLIT, 32'h2, "g0 split after reset");
		rd_chk(vcpu_prio_pkg::ENC_VIRT_CONTROL, ctl_exp(1'b0, 1'b0), "ctl after reset");
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule : virtual_cpu_iface_priority_regs_tb
